// ===== design/udp_pkg.sv
// udp_pkg: register map, field positions, reset values and state types
// for the device-mode power control and transmit status block.
// assumes 32-bit apb with one aligned word per register index.
package udp_pkg;

  // ----------------------------------------
  // register map (index, byte address = 4 x index)
  // ----------------------------------------
  localparam logic [11:0] PWR_IDX   = 12'h001;
  localparam logic [11:0] TXIS_IDX  = 12'h002;
  localparam logic [11:0] PWR_ADDR  = PWR_IDX << 2;
  localparam logic [11:0] TXIS_ADDR = TXIS_IDX << 2;

  // ----------------------------------------
  // power/control fields
  // ----------------------------------------
  localparam int unsigned ISO_BIT  = 7;
  localparam int unsigned SOFT_BIT = 6;
  localparam int unsigned RSV_LSB  = 4;
  localparam int unsigned BRST_BIT = 3;
  localparam int unsigned RSM_BIT  = 2;
  localparam int unsigned SUSP_BIT = 1;
  localparam int unsigned PD_BIT   = 0;
  localparam logic [1:0]  PWR_RSV  = 2'h2;
  localparam logic [7:0]  PWR_RST  = 8'h20;

  // ----------------------------------------
  // transmit status fields
  // ----------------------------------------
  localparam int unsigned  NUM_EP   = 4;
  localparam logic [15:0]  TXIS_RST = 16'h0000;

  // ----------------------------------------
  // resume timing owed by software
  // ----------------------------------------
  localparam int unsigned RSM_MIN_MS = 10;
  localparam int unsigned RSM_MAX_MS = 15;

  typedef enum logic {
    UDP_IDLE,
    UDP_HOLD
  } udp_hold_t;

endpackage

// ===== design/udp_sync.sv
// udp_sync: two-flop synchroniser for a group of pin levels.
// assumes inputs are levels, asynchronous to clk.
`timescale 1ns/1ps
module udp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } udp_sync_st_t;

  udp_sync_st_t st_ff;
  udp_sync_st_t nxt_st;

  // first stage feeds only the second stage
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;

endmodule

// ===== design/udp_top.sv
// udp_top: device-mode power/control register, soft connect, resume
// drive, suspend flag, isochronous hold and transmit status register.
// assumes apb master on clk; line pins asynchronous, link events on clk.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module udp_top #(
  parameter int unsigned NEP = udp_pkg::NUM_EP
) (
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           clk_en,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic           bus_reset_pin,
  input  wire logic           suspend_pin,
  input  wire logic           sof_tok,
  input  wire logic           in_tok,
  input  wire logic           tx_packet_ready,
  input  wire logic           ep_is_iso,
  input  wire logic [NEP-1:0] ep_irq_evt,
  input  wire logic [NEP-1:0] ep_configured,
  input  wire logic           link_dp,
  input  wire logic           link_dm,
  input  wire logic           link_oe,
  output logic                tx_send,
  output logic                tx_zero_len,
  output logic                dp_out,
  output logic                dp_oe,
  output logic                dm_out,
  output logic                dm_oe,
  output logic                soft_connect,
  output logic                phy_power_down
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic              iso_update_hold;
    logic              soft_connect;
    logic              resume;
    logic              resume_act;
    logic              suspend;
    logic              susp_prev;
    logic              phy_power_down;
    logic [NEP-1:0]    irq;
    logic [31:0]       rdata;
    udp_pkg::udp_hold_t hold;
    logic              tx_send;
    logic              tx_zero_len;
    logic              dp;
    logic              dm;
    logic              oe;
  } udp_st_t;

  udp_st_t st_ff;
  udp_st_t nxt_st;

  logic [1:0] pin_s;
  logic       brst_s;
  logic       susp_s;

  logic       setup;
  logic       access;
  logic       wr_pwr;
  logic       rd_txis;
  logic       susp_rise;
  logic       iso_path;
  logic [7:0] pwr_rd;
  logic [NEP-1:0] irq_vis;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  udp_sync #(
    .W (2)
  ) u_pin_sync (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .d      ({bus_reset_pin, suspend_pin}),
    .q      (pin_s)
  );

  assign brst_s = pin_s[1];
  assign susp_s = pin_s[0];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign setup   = psel && !penable;
  assign access  = psel && penable && clk_en;
  assign wr_pwr  = access && pwrite && (paddr == udp_pkg::PWR_ADDR);
  assign rd_txis = access && !pwrite && (paddr == udp_pkg::TXIS_ADDR);

  assign susp_rise = susp_s && !st_ff.susp_prev;
  assign iso_path  = st_ff.iso_update_hold && ep_is_iso;

  // unconfigured endpoints never show
  assign irq_vis = st_ff.irq & ep_configured;

  // reserved field is a constant, not a stored bit
  always_comb begin
    pwr_rd = '0;
    pwr_rd[udp_pkg::ISO_BIT]  = st_ff.iso_update_hold;
    pwr_rd[udp_pkg::SOFT_BIT] = st_ff.soft_connect;
    pwr_rd[udp_pkg::RSV_LSB +: 2] = udp_pkg::PWR_RSV;
    pwr_rd[udp_pkg::BRST_BIT] = brst_s;
    pwr_rd[udp_pkg::RSM_BIT]  = st_ff.resume;
    pwr_rd[udp_pkg::SUSP_BIT] = st_ff.suspend;
    pwr_rd[udp_pkg::PD_BIT]   = st_ff.phy_power_down;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.tx_send     = 1'b0;
    nxt_st.tx_zero_len = 1'b0;
    nxt_st.susp_prev   = susp_s;

    // read data is captured in setup so the access edge can clear it
    if (setup) begin
      if (pwrite) begin
        nxt_st.rdata = '0;
      end else if (paddr == udp_pkg::PWR_ADDR) begin
        nxt_st.rdata = {24'h000000, pwr_rd};
      end else if (paddr == udp_pkg::TXIS_ADDR) begin
        nxt_st.rdata = {{(32-NEP){1'b0}}, irq_vis};
      end else begin
        nxt_st.rdata = '0;
      end
    end

    // only writable fields are taken; others ignored
    if (wr_pwr) begin
      nxt_st.iso_update_hold = pwdata[udp_pkg::ISO_BIT];
      nxt_st.soft_connect    = pwdata[udp_pkg::SOFT_BIT];
      nxt_st.resume          = pwdata[udp_pkg::RSM_BIT];
      if (pwdata[udp_pkg::RSM_BIT]) begin
        if (st_ff.suspend) begin
          nxt_st.resume_act = 1'b1;
        end
      end else begin
        nxt_st.resume_act = 1'b0;
      end
      if (pwdata[udp_pkg::PD_BIT]) begin
        nxt_st.phy_power_down = 1'b1;
      end
    end

    // suspend: cleared by status read or resume set; new entry wins
    if (rd_txis || (wr_pwr && pwdata[udp_pkg::RSM_BIT])) begin
      nxt_st.suspend = 1'b0;
    end
    if (susp_rise) begin
      nxt_st.suspend = 1'b1;
    end

    // reported bits clear; events arriving now survive
    if (rd_txis) begin
      nxt_st.irq = st_ff.irq & ~st_ff.rdata[NEP-1:0];
    end
    // bit 0 is the control endpoint either direction, 1..3 device in
    nxt_st.irq = nxt_st.irq | (ep_irq_evt & ep_configured);

    // isochronous hold of a ready packet
    case (st_ff.hold)
      udp_pkg::UDP_IDLE: begin
        if (tx_packet_ready) begin
          if (iso_path) begin
            nxt_st.hold = udp_pkg::UDP_HOLD;
          end else begin
            nxt_st.tx_send = 1'b1;
          end
        end
      end
      udp_pkg::UDP_HOLD: begin
        if (sof_tok) begin
          nxt_st.tx_send = 1'b1;
          nxt_st.hold    = udp_pkg::UDP_IDLE;
        end else if (in_tok) begin
          nxt_st.tx_zero_len = 1'b1;
        end
      end
      default: begin
        nxt_st.hold = udp_pkg::UDP_IDLE;
      end
    endcase

    // line drive: resume k-state overrides link data
    if (!st_ff.soft_connect) begin
      nxt_st.oe = 1'b0;
      nxt_st.dp = 1'b0;
      nxt_st.dm = 1'b0;
    end else if (st_ff.resume_act) begin
      nxt_st.oe = 1'b1;
      nxt_st.dp = 1'b0;
      nxt_st.dm = 1'b1;
    end else begin
      nxt_st.oe = link_oe;
      nxt_st.dp = link_dp;
      nxt_st.dm = link_dm;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // all-zero reset gives power 0x20 readback and idle hold state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata         = st_ff.rdata;
  assign pready         = psel && penable && clk_en;
  assign pslverr        = 1'b0;
  assign tx_send        = st_ff.tx_send;
  assign tx_zero_len    = st_ff.tx_zero_len;
  assign dp_out         = st_ff.dp;
  assign dm_out         = st_ff.dm;
  assign dp_oe          = st_ff.oe;
  assign dm_oe          = st_ff.oe;
  assign soft_connect   = st_ff.soft_connect;
  assign phy_power_down = st_ff.phy_power_down;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_iso_sof_send: assert property (
    (st_ff.hold == udp_pkg::UDP_HOLD) && sof_tok && clk_en
    |=> tx_send && (st_ff.hold == udp_pkg::UDP_IDLE))
    else $error("held packet not sent at sof");

  chk_iso_in_zlp: assert property (
    (st_ff.hold == udp_pkg::UDP_HOLD) && in_tok && !sof_tok && clk_en
    |=> tx_zero_len && !tx_send)
    else $error("in token during hold gave no zero-length");

  chk_noniso_direct: assert property (
    (st_ff.hold == udp_pkg::UDP_IDLE) && tx_packet_ready
    && !(st_ff.iso_update_hold && ep_is_iso) && clk_en
    |=> tx_send && (st_ff.hold == udp_pkg::UDP_IDLE))
    else $error("non-iso packet was held");

  chk_soft_connect_tri: assert property (
    !soft_connect && clk_en |=> !dp_oe && !dm_oe)
    else $error("lines driven while disconnected");

  chk_bus_reset_rd: assert property (
    setup && !pwrite && (paddr == udp_pkg::PWR_ADDR) && clk_en
    |=> prdata[udp_pkg::BRST_BIT] == $past(brst_s))
    else $error("bus reset bit does not follow line");

  chk_resume_drive: assert property (
    wr_pwr && pwdata[udp_pkg::RSM_BIT] && st_ff.suspend
    && pwdata[udp_pkg::SOFT_BIT] ##1 clk_en [*2]
    |-> dp_oe && !dp_out && dm_out)
    else $error("resume signaling not started");

  chk_suspend_clear: assert property (
    rd_txis && !susp_rise |=> !st_ff.suspend)
    else $error("suspend not cleared by status read");

  chk_pd_sticky: assert property (
    phy_power_down |=> phy_power_down)
    else $error("phy power down dropped without reset");

  chk_pwr_reserved: assert property (
    setup && !pwrite && (paddr == udp_pkg::PWR_ADDR) && clk_en
    |=> (prdata[5:4] == udp_pkg::PWR_RSV) && (prdata[31:8] == '0))
    else $error("power reserved bits wrong");

  chk_txis_width: assert property (
    $past(setup && !pwrite && (paddr == udp_pkg::TXIS_ADDR) && clk_en)
    |-> prdata[31:NEP] == '0)
    else $error("tx status upper bits nonzero");

  chk_unconf_zero: assert property (
    setup && !pwrite && (paddr == udp_pkg::TXIS_ADDR) && clk_en
    |=> (prdata[NEP-1:0] & ~$past(ep_configured)) == '0)
    else $error("unconfigured endpoint reported");

  chk_rc_clear: assert property (
    rd_txis && (st_ff.rdata[0] == 1'b1) && !ep_irq_evt[0]
    |=> st_ff.irq[0] == 1'b0)
    else $error("status read did not clear bit");

  chk_suspend_set: assert property (
    susp_rise && clk_en |=> st_ff.suspend)
    else $error("suspend entry not flagged");

  chk_resume_end: assert property (
    wr_pwr && !pwdata[udp_pkg::RSM_BIT]
    |=> !st_ff.resume_act)
    else $error("resume signaling not ended");

  chk_ep0_capture: assert property (
    clk_en && ep_irq_evt[0] && ep_configured[0]
    |=> st_ff.irq[0])
    else $error("control endpoint event lost");

  chk_pd_set: assert property (
    wr_pwr && pwdata[udp_pkg::PD_BIT]
    |=> phy_power_down)
    else $error("phy power down not set");

endmodule

// ===== dv/udp_host_model.sv
// udp_host_model: usb host standing on the far side of the device lines.
// assumes the bench calls its tasks from the clk domain of the device.
`timescale 1ns/1ps
module udp_host_model (
  input  wire logic clk,
  input  wire logic dp_out,
  input  wire logic dp_oe,
  input  wire logic dm_out,
  input  wire logic dm_oe,
  output logic      bus_reset_pin,
  output logic      suspend_pin,
  output logic      sof_tok,
  output logic      in_tok,
  output logic      line_dp,
  output logic      line_dm
);
  // ----------------------------------------
  // line levels
  // ----------------------------------------
  // host pull-downs take a released line low, never the last driven value
  assign line_dp = dp_oe ? dp_out : 1'b0;
  assign line_dm = dm_oe ? dm_out : 1'b0;

  initial begin
    bus_reset_pin = 1'b0;
    suspend_pin   = 1'b0;
    sof_tok       = 1'b0;
    in_tok        = 1'b0;
  end

  // ----------------------------------------
  // bus conditions and tokens
  // ----------------------------------------
  task pins(input logic rst, input logic idle);
    @(posedge clk);
    bus_reset_pin <= rst;
    suspend_pin   <= idle;
  endtask

  // one-cycle token: sof when sof is 1, else an in token
  task tok(input logic sof);
    @(posedge clk);
    sof_tok <= sof;
    in_tok  <= !sof;
    @(posedge clk);
    sof_tok <= 1'b0;
    in_tok  <= 1'b0;
  endtask
endmodule

// ===== dv/usb_device_power_and_tx_irq_tb_top.sv
// usb_device_power_and_tx_irq_tb_top: self-checking bench for udp_top.
// assumes zero-wait apb slave and the host model on the line side.
`timescale 1ns/1ps
module usb_device_power_and_tx_irq_tb_top;
  // resume hold scaled far below 10 ms so the run stays short
  localparam int RSM_WAIT = 200;
  localparam logic [11:0] PW = udp_pkg::PWR_ADDR;
  localparam logic [11:0] TX = udp_pkg::TXIS_ADDR;
  logic        clk, nrst, clk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic        tx_packet_ready, ep_is_iso, link_dp, link_dm, link_oe;
  logic [3:0]  ep_irq_evt, ep_configured;
  wire  [31:0] prdata;
  wire         pready, pslverr, tx_send, tx_zero_len, dp_out, dp_oe, dm_out, dm_oe;
  wire         soft_connect, phy_power_down, bus_reset_pin, suspend_pin, sof_tok, in_tok;
  wire         line_dp, line_dm;
  int          miscompares, check_count;

  udp_top i_udp_top (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_reset_pin(bus_reset_pin), .suspend_pin(suspend_pin),
    .sof_tok(sof_tok), .in_tok(in_tok), .tx_packet_ready(tx_packet_ready),
    .ep_is_iso(ep_is_iso), .ep_irq_evt(ep_irq_evt), .ep_configured(ep_configured),
    .link_dp(link_dp), .link_dm(link_dm), .link_oe(link_oe), .tx_send(tx_send),
    .tx_zero_len(tx_zero_len), .dp_out(dp_out), .dp_oe(dp_oe), .dm_out(dm_out),
    .dm_oe(dm_oe), .soft_connect(soft_connect), .phy_power_down(phy_power_down)
  );
  udp_host_model i_udp_host_model (
    .clk(clk), .dp_out(dp_out), .dp_oe(dp_oe), .dm_out(dm_out), .dm_oe(dm_oe),
    .bus_reset_pin(bus_reset_pin), .suspend_pin(suspend_pin), .sof_tok(sof_tok),
    .in_tok(in_tok), .line_dp(line_dp), .line_dm(line_dm)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task tx_go(input logic iso);
    @(posedge clk);
    tx_packet_ready <= 1'b1;
    ep_is_iso       <= iso;
    @(posedge clk);
    tx_packet_ready <= 1'b0;
  endtask
  task pulse_ev(input logic [3:0] v);
    @(posedge clk);
    ep_irq_evt <= v;
    @(posedge clk);
    ep_irq_evt <= 4'h0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset_ro();
    rdchk("pwr", PW, 32'h00000020);
    rdchk("txis", TX, 32'h00000000);
    rdchk("unmapped", 12'h0FC, 32'h00000000);
    chk("slverr", pslverr, 1'b0);
    apb(1'b1, PW, 32'h0000003A);
    rdchk("pwr ro", PW, 32'h00000020);
    apb(1'b1, TX, 32'h0000FFFF);
    rdchk("txis ro", TX, 32'h00000000);
  endtask
  task t_soft();
    apb(1'b1, PW, 32'h00000040);
    wait_n(2);
    chk("lines on", {dp_out, dp_oe, dm_out, dm_oe, soft_connect}, 5'b11011);
    apb(1'b1, PW, 32'h00000000);
    wait_n(2);
    chk("lines off", {dp_oe, dm_oe, soft_connect}, 3'b000);
  endtask
  task t_bus_reset();
    i_udp_host_model.pins(1'b1, 1'b0);
    wait_n(4);
    rdchk("rst on", PW, 32'h00000028);
    i_udp_host_model.pins(1'b0, 1'b0);
    wait_n(4);
    rdchk("rst off", PW, 32'h00000020);
  endtask
  task t_resume();
    apb(1'b1, PW, 32'h00000040);
    i_udp_host_model.pins(1'b0, 1'b1);
    wait_n(4);
    rdchk("susp", PW, 32'h00000062);
    apb(1'b1, PW, 32'h00000044);
    wait_n(2);
    chk("k drive", {line_dp, line_dm, dp_oe, dm_oe}, 4'b0111);
    rdchk("susp clr rsm", PW, 32'h00000064);
    wait_n(RSM_WAIT);
    apb(1'b1, PW, 32'h00000040);
    wait_n(2);
    chk("k end", {line_dp, line_dm, dp_oe, dm_oe}, 4'b1011);
    i_udp_host_model.pins(1'b0, 1'b0);
    wait_n(4);
    i_udp_host_model.pins(1'b0, 1'b1);
    wait_n(4);
    rdchk("susp again", PW, 32'h00000062);
    rdchk("txis empty", TX, 32'h00000000);
    rdchk("susp clr rd", PW, 32'h00000060);
    apb(1'b1, PW, 32'h00000044);
    wait_n(2);
    chk("no k awake", {line_dp, line_dm}, 2'b10);
    apb(1'b1, PW, 32'h00000000);
  endtask
  task t_txis();
    for (int n = 0; n < 4; n++) begin
      pulse_ev(4'h1 << n);
      rdchk("txis ep", TX, 32'h1 << n);
    end
    @(posedge clk);
    ep_configured <= 4'hB;
    pulse_ev(4'hF);
    rdchk("txis cfg", TX, 32'h0000000B);
    rdchk("txis clr", TX, 32'h00000000);
  endtask
  task t_iso();
    apb(1'b1, PW, 32'h000000C0);
    tx_go(1'b1);
    repeat (3) begin
      wait_n(0);
      chk("held", {tx_send, tx_zero_len}, 2'b00);
      @(posedge clk);
    end
    i_udp_host_model.tok(1'b1);
    wait_n(0);
    chk("sof send", {tx_send, tx_zero_len}, 2'b10);
    tx_go(1'b1);
    i_udp_host_model.tok(1'b0);
    wait_n(0);
    chk("in zlp", {tx_send, tx_zero_len}, 2'b01);
    // packet is still held after the zero-length reply; sof releases it
    i_udp_host_model.tok(1'b1);
    wait_n(0);
    chk("zlp then sof", {tx_send, tx_zero_len}, 2'b10);
    tx_go(1'b0);
    wait_n(0);
    chk("non iso", {tx_send, tx_zero_len}, 2'b10);
    apb(1'b1, PW, 32'h00000040);
    tx_go(1'b1);
    wait_n(0);
    chk("hold off", {tx_send, tx_zero_len}, 2'b10);
  endtask
  task t_pd();
    apb(1'b1, PW, 32'h00000001);
    wait_n(1);
    chk("pd set", phy_power_down, 1'b1);
    apb(1'b1, PW, 32'h00000000);
    wait_n(1);
    chk("pd kept", phy_power_down, 1'b1);
    rdchk("pwr pd", PW, 32'h00000021);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    {nrst, psel, penable, pwrite, tx_packet_ready, ep_is_iso} = 6'b0;
    {paddr, pwdata, ep_irq_evt} = '0;
    clk_en        = 1'b1;
    ep_configured = 4'hF;
    {link_dp, link_dm, link_oe} = 3'b101;
    miscompares   = 0;
    check_count   = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset_ro();
    t_soft();
    t_bus_reset();
    t_resume();
    t_txis();
    t_iso();
    t_pd();
    final_report();
  end
endmodule
